/* File: logic/fbc_pkg.sv */
// Constants, opcode fields, register map and helpers for the executor.
// Assumes a 14-bit instruction word and an 8-bit register file.
// What this block does
// - AND accumulator with file, destination bit, zero
// - Bit clear in file register, flags untouched
// - Bit set in file register, flags untouched
// - Skip next when tested bit is zero
// - Skip next when tested bit is one
// - Call pushes program counter plus one
// - Call target from immediate and page latch
// - Call takes two cycles, flags untouched
// - Watchdog clear zeroes counter and prescaler
// - Watchdog clear sets timeout and powerdown flags
// - File clear writes zero, sets zero flag
// - Taken branch or skip adds a nop cycle
package fbc_pkg;
    // Operand and address widths
    localparam int FBC_FILE_AW = 7;
    localparam int FBC_PC_W = 13;
    localparam int FBC_CODE_W = 14;
    // Opcode fields
    localparam logic [1:0] FBC_OP_BITOP = 2'h1;
    localparam logic [1:0] FBC_BIT_CLR = 2'h0;
    localparam logic [1:0] FBC_BIT_SET = 2'h1;
    localparam logic [1:0] FBC_BIT_TSZ = 2'h2;
    localparam logic [1:0] FBC_BIT_TSO = 2'h3;
    localparam logic [2:0] FBC_OP_CALL = 3'h4;
    localparam logic [13:0] FBC_CODE_WDTCLR = 14'h0064;
    localparam logic [5:0] FBC_OP_AND = 6'h05;
    localparam logic [5:0] FBC_OP_INV = 6'h09;
    localparam logic [6:0] FBC_OP_FILE_ZERO_OP = 7'h03;
    // Page latch bits feeding the upper program counter
    localparam int FBC_PAGE_HI = 4;
    localparam int FBC_PAGE_LO = 3;
    // Register offsets
    localparam logic [7:0] FBC_OFS_CTRL = 8'h00;
    localparam logic [7:0] FBC_OFS_PAGE = 8'h04;
    localparam logic [7:0] FBC_OFS_ACCUM = 8'h08;
    localparam logic [7:0] FBC_OFS_STATUS = 8'h0c;
    // Field positions
    localparam int FBC_CTRL_EN = 0;
    localparam int FBC_STAT_Z = 0;
    localparam int FBC_STAT_PD_N = 1;
    localparam int FBC_STAT_TO_N = 2;
    localparam int FBC_STAT_UNSUP = 3;
    // Reset values
    localparam logic FBC_RST_EN = 1'h1;
    localparam logic [7:0] FBC_RST_ACCUM = 8'h00;
    localparam logic [7:0] FBC_RST_PAGE = 8'h00;
    localparam logic FBC_RST_FLAG_N = 1'h1;
    // Value the watchdog counter takes on clear
    localparam logic [7:0] FBC_WDT_CLEAR_VAL = 8'h00;
    // Data path operations
    typedef enum logic [2:0] {
        FBC_ALU_PASS, FBC_ALU_AND, FBC_ALU_INV, FBC_ALU_ZERO, FBC_ALU_CLRB, FBC_ALU_SETB
    } fbc_alu_t;
    // One-hot mask for a bit position
    function automatic logic [7:0] fbc_bit_mask(input logic [2:0] b);
        fbc_bit_mask = 8'h01 << b;
    endfunction : fbc_bit_mask
endpackage : fbc_pkg

/* File: logic/fbc_alu.sv */
// Byte data path for the executor: AND, invert, zero, bit clear and set.
// Purely combinational; the caller registers the results.
`timescale 1ns/100ps
`default_nettype none
module fbc_alu
    import fbc_pkg::*;
(
    input wire fbc_alu_t op,
    input wire logic [7:0] accum,
    input wire logic [7:0] fdata,
    input wire logic [2:0] bsel,
    output logic [7:0] result,
    output logic zero,
    output logic bit_val
);
    // Operation select
    always_comb begin
        case (op)
            FBC_ALU_AND: result = accum & fdata;
            FBC_ALU_INV: result = ~fdata;
            FBC_ALU_ZERO: result = 8'h00;
            FBC_ALU_CLRB: result = fdata & ~fbc_bit_mask(bsel);
            FBC_ALU_SETB: result = fdata | fbc_bit_mask(bsel);
            default: result = fdata;
        endcase
    end
    // Zero detect and tested bit
    assign zero = (result == 8'h00);
    assign bit_val = |(fdata & fbc_bit_mask(bsel));
endmodule : fbc_alu
`default_nettype wire

/* File: logic/fbc_exec.sv */
// Executor for bit, AND, invert, clear, call and watchdog-clear instructions.
// Assumes the fetch stage presents the word, its address and the operand byte
// read from the register file together, all synchronous to clk.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module fbc_exec
    import fbc_pkg::*;
#(
    parameter int FILE_AW = FBC_FILE_AW,
    parameter int PC_W = FBC_PC_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_valid,
    input wire logic [13:0] instr_code,
    input wire logic [12:0] instr_pc,
    input wire logic [7:0] file_rdata,
    output logic instr_ready,
    output logic file_we,
    output logic [6:0] file_addr,
    output logic [7:0] file_wdata,
    output logic pc_load,
    output logic [12:0] pc_target,
    output logic stack_push,
    output logic [12:0] stack_data,
    output logic fetch_flush,
    output logic wdt_clear,
    output logic wdt_presc_clear,
    output logic [7:0] wdt_value,
    input wire logic timeout_evt,
    input wire logic sleep_evt
);
    // Widths are fixed by the instruction format
    if (FILE_AW != 7 || PC_W != 13) begin : g_bad_width
        $error("fbc_exec: unsupported width parameters");
    end

    typedef enum logic {FBC_ST_RUN, FBC_ST_NOP} fbc_state_t;

    // Bus side registers
    logic en_q, en_d; // Core enable from software
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    // Execution registers
    fbc_state_t state_q, state_d;
    logic ready_q, ready_d;
    logic discard_q, discard_d; // Next word is dropped as a nop
    logic [7:0] accum_q, accum_d;
    logic [7:0] page_q, page_d;
    logic z_q, z_d;
    logic to_n_q, to_n_d;
    logic pd_n_q, pd_n_d;
    logic unsup_q, unsup_d;
    logic fwe_q, fwe_d;
    logic [6:0] faddr_q, faddr_d;
    logic [7:0] fwdata_q, fwdata_d;
    logic pcl_q, pcl_d;
    logic [12:0] pct_q, pct_d;
    logic push_q, push_d;
    logic [12:0] sdata_q, sdata_d;
    logic flush_q, flush_d;
    logic wdt_q, wdt_d;

    // Bus decode; a write lands only on the completing edge
    logic apb_done;
    logic apb_wr;
    logic wr_ctrl, wr_page, wr_accum, wr_status;
    assign apb_done = psel && penable && pready_q;
    assign apb_wr = apb_done && pwrite;
    assign wr_ctrl = apb_wr && (paddr == FBC_OFS_CTRL);
    assign wr_page = apb_wr && (paddr == FBC_OFS_PAGE);
    assign wr_accum = apb_wr && (paddr == FBC_OFS_ACCUM);
    assign wr_status = apb_wr && (paddr == FBC_OFS_STATUS);

    // Instruction fields
    logic accept, exec_ok;
    logic dest;
    logic [2:0] bsel;
    logic [1:0] bkind;
    logic is_and, is_inv, is_file_zero_op, is_bitop, is_call, is_wdt;
    assign accept = instr_valid && ready_q;
    assign exec_ok = accept && !discard_q;
    assign dest = instr_code[7];
    assign bsel = instr_code[9:7];
    assign bkind = instr_code[11:10];
    assign is_and = (instr_code[13:8] == FBC_OP_AND);
    assign is_inv = (instr_code[13:8] == FBC_OP_INV);
    assign is_file_zero_op = (instr_code[13:7] == FBC_OP_FILE_ZERO_OP);
    assign is_bitop = (instr_code[13:12] == FBC_OP_BITOP);
    assign is_call = (instr_code[13:11] == FBC_OP_CALL);
    assign is_wdt = (instr_code == FBC_CODE_WDTCLR);

    // Data path operation for the current word
    fbc_alu_t alu_op;
    logic [7:0] alu_res;
    logic alu_zero, alu_bit;
    always_comb begin
        if (is_and) alu_op = FBC_ALU_AND;
        else if (is_inv) alu_op = FBC_ALU_INV;
        else if (is_file_zero_op) alu_op = FBC_ALU_ZERO;
        else if (is_bitop && bkind == FBC_BIT_CLR) alu_op = FBC_ALU_CLRB;
        else if (is_bitop && bkind == FBC_BIT_SET) alu_op = FBC_ALU_SETB;
        else alu_op = FBC_ALU_PASS;
    end

    fbc_alu u_alu (
        .op(alu_op),
        .accum(accum_q),
        .fdata(file_rdata),
        .bsel(bsel),
        .result(alu_res),
        .zero(alu_zero),
        .bit_val(alu_bit)
    );

    // Bus slave next state: one wait state, then a registered answer
    always_comb begin
        en_d = en_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        if (wr_ctrl) begin
            en_d = pwdata[FBC_CTRL_EN];
        end
        if (psel && penable && !pready_q) begin
            // Answer prepared one cycle into the access phase
            pready_d = 1'b1;
            prdata_d = 32'h0000_0000;
            case (paddr)
                FBC_OFS_CTRL: prdata_d[FBC_CTRL_EN] = en_q;
                FBC_OFS_PAGE: prdata_d[7:0] = page_q;
                FBC_OFS_ACCUM: prdata_d[7:0] = accum_q;
                FBC_OFS_STATUS: begin
                    prdata_d[FBC_STAT_Z] = z_q;
                    prdata_d[FBC_STAT_PD_N] = pd_n_q;
                    prdata_d[FBC_STAT_TO_N] = to_n_q;
                    prdata_d[FBC_STAT_UNSUP] = unsup_q;
                end
                default: pslverr_d = 1'b1; // Unmapped reads zero with error
            endcase
        end
    end

    // Bus slave registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            en_q <= FBC_RST_EN;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            en_q <= en_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // Execution next state
    always_comb begin
        state_d = state_q;
        discard_d = discard_q;
        accum_d = accum_q;
        page_d = page_q;
        z_d = z_q;
        to_n_d = to_n_q;
        pd_n_d = pd_n_q;
        unsup_d = unsup_q;
        fwe_d = 1'b0;
        faddr_d = faddr_q;
        fwdata_d = fwdata_q;
        pcl_d = 1'b0;
        pct_d = pct_q;
        push_d = 1'b0;
        sdata_d = sdata_q;
        flush_d = 1'b0;
        wdt_d = 1'b0;
        // Software writes first, so a same-cycle instruction wins
        if (wr_page) page_d = pwdata[7:0];
        if (wr_accum) accum_d = pwdata[7:0];
        if (wr_status && pwdata[FBC_STAT_UNSUP]) unsup_d = 1'b0;
        // Watchdog and sleep events clear the active-low flags
        if (timeout_evt) to_n_d = 1'b0;
        if (sleep_evt) pd_n_d = 1'b0;
        case (state_q)
            FBC_ST_RUN: begin
                if (accept && discard_q) begin
                    // Skipped word runs as the nop cycle
                    discard_d = 1'b0;
                end else if (exec_ok) begin
                    faddr_d = instr_code[6:0];
                    if (is_and || is_inv) begin
                        z_d = alu_zero;
                        if (dest) begin
                            fwe_d = 1'b1;
                            fwdata_d = alu_res;
                        end else begin
                            accum_d = alu_res;
                        end
                    end else if (is_file_zero_op) begin
                        fwe_d = 1'b1;
                        fwdata_d = alu_res;
                        z_d = 1'b1;
                    end else if (is_bitop) begin
                        case (bkind)
                            FBC_BIT_CLR, FBC_BIT_SET: begin
                                fwe_d = 1'b1;
                                fwdata_d = alu_res;
                            end
                            FBC_BIT_TSZ: discard_d = !alu_bit;
                            default: discard_d = alu_bit;
                        endcase
                    end else if (is_call) begin
                        push_d = 1'b1;
                        sdata_d = 13'(instr_pc + 13'h0001);
                        pcl_d = 1'b1;
                        pct_d = {page_q[FBC_PAGE_HI:FBC_PAGE_LO], instr_code[10:0]};
                        flush_d = 1'b1;
                        state_d = FBC_ST_NOP;
                    end else if (is_wdt) begin
                        wdt_d = 1'b1;
                        to_n_d = 1'b1;
                        pd_n_d = 1'b1;
                    end else begin
                        // Words outside this group are flagged, set wins
                        unsup_d = 1'b1;
                    end
                end
            end
            FBC_ST_NOP: state_d = FBC_ST_RUN;
            default: state_d = FBC_ST_RUN;
        endcase
    end

    // Ready drops for the call's nop cycle and while disabled
    assign ready_d = en_d && (state_d == FBC_ST_RUN);

    // Execution registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= FBC_ST_RUN;
            ready_q <= 1'b0;
            discard_q <= 1'b0;
            accum_q <= FBC_RST_ACCUM;
            page_q <= FBC_RST_PAGE;
            z_q <= 1'b0;
            to_n_q <= FBC_RST_FLAG_N;
            pd_n_q <= FBC_RST_FLAG_N;
            unsup_q <= 1'b0;
            fwe_q <= 1'b0;
            faddr_q <= 7'h00;
            fwdata_q <= 8'h00;
            pcl_q <= 1'b0;
            pct_q <= 13'h0000;
            push_q <= 1'b0;
            sdata_q <= 13'h0000;
            flush_q <= 1'b0;
            wdt_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ready_q <= ready_d;
            discard_q <= discard_d;
            accum_q <= accum_d;
            page_q <= page_d;
            z_q <= z_d;
            to_n_q <= to_n_d;
            pd_n_q <= pd_n_d;
            unsup_q <= unsup_d;
            fwe_q <= fwe_d;
            faddr_q <= faddr_d;
            fwdata_q <= fwdata_d;
            pcl_q <= pcl_d;
            pct_q <= pct_d;
            push_q <= push_d;
            sdata_q <= sdata_d;
            flush_q <= flush_d;
            wdt_q <= wdt_d;
        end
    end

    // Outputs straight from flops, except wdt_value, which is the constant FBC_WDT_CLEAR_VAL
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign instr_ready = ready_q;
    assign file_we = fwe_q;
    assign file_addr = faddr_q;
    assign file_wdata = fwdata_q;
    assign pc_load = pcl_q;
    assign pc_target = pct_q;
    assign stack_push = push_q;
    assign stack_data = sdata_q;
    assign fetch_flush = flush_q;
    assign wdt_clear = wdt_q;
    assign wdt_presc_clear = wdt_q; // Prescaler cleared with the counter
    assign wdt_value = FBC_WDT_CLEAR_VAL;

    // Checks
    and_to_file_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec_ok && is_and && dest |=> file_we
            && file_wdata == ($past(accum_q) & $past(file_rdata)))
        else $error("and result not written to file");
    and_to_accum_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec_ok && is_and && !dest |=> !file_we
            && accum_q == ($past(accum_q) & $past(file_rdata))
            && z_q == (accum_q == 8'h00))
        else $error("and result not in accumulator");
    bit_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec_ok && is_bitop && bkind == FBC_BIT_CLR |=> file_we && $stable(z_q)
            && file_wdata == ($past(file_rdata) & ~fbc_bit_mask($past(bsel))))
        else $error("bit clear wrong");
    bit_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec_ok && is_bitop && bkind == FBC_BIT_SET |=> file_we && $stable(z_q)
            && file_wdata == ($past(file_rdata) | fbc_bit_mask($past(bsel))))
        else $error("bit set wrong");
    skip_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec_ok && is_bitop && bkind == FBC_BIT_TSZ |=> discard_q == !$past(alu_bit))
        else $error("skip on zero wrong");
    skip_one_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec_ok && is_bitop && bkind == FBC_BIT_TSO |=> discard_q == $past(alu_bit))
        else $error("skip on one wrong");
    skipped_nop_a: assert property (@(posedge clk) disable iff (!rst_n)
        accept && discard_q |=> !file_we && !pc_load && !stack_push && !discard_q)
        else $error("skipped word had effect");
    call_push_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec_ok && is_call |=> stack_push && stack_data == 13'($past(instr_pc) + 13'h0001))
        else $error("call push wrong");
    call_target_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec_ok && is_call |=> pc_load
            && pc_target == {$past(page_q[4:3]), $past(instr_code[10:0])})
        else $error("call target wrong");
    call_two_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec_ok && is_call |=> !instr_ready && $stable(z_q) ##1 state_q == FBC_ST_RUN)
        else $error("call not two cycles");
    wdt_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec_ok && is_wdt |=> wdt_clear && wdt_presc_clear && wdt_value == 8'h00)
        else $error("watchdog not cleared");
    wdt_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec_ok && is_wdt && !timeout_evt && !sleep_evt |=> to_n_q && pd_n_q)
        else $error("watchdog flags not set");
    file_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec_ok && is_file_zero_op |=> file_we && file_wdata == 8'h00 && z_q)
        else $error("file clear wrong");
    invert_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec_ok && is_inv && dest |=> file_we && file_wdata == ~$past(file_rdata))
        else $error("invert wrong");
endmodule : fbc_exec
`default_nettype wire

/* File: verification/fbc_core_model.sv */
// Partner model of the core: register file image and return stack top.
// Assumes one clock; the bench preloads bytes only between instructions.
`timescale 1ns/100ps
`default_nettype none
module fbc_core_model (
    input wire logic clk,
    input wire logic rd_en,
    input wire logic [6:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic file_we,
    input wire logic [6:0] file_addr,
    input wire logic [7:0] file_wdata,
    input wire logic pre_we,
    input wire logic [6:0] pre_addr,
    input wire logic [7:0] pre_data,
    input wire logic stack_push,
    input wire logic [12:0] stack_data,
    output logic [12:0] stack_top
);
    logic [7:0] mem [0:127]; // Register file image
    // Operand byte; inverted outside a presented word so stale data never passes
    assign rd_data = rd_en ? mem[rd_addr] : ~mem[rd_addr];
    // Executor writes, bench preload and stack push
    always_ff @(posedge clk) begin
        if (file_we) begin
            mem[file_addr] <= file_wdata;
        end
        if (pre_we) begin
            mem[pre_addr] <= pre_data;
        end
        if (stack_push) begin
            stack_top <= stack_data;
        end
    end
endmodule : fbc_core_model
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench: APB register access and one task per instruction kind.
// Assumes fbc_exec and the core model are compiled first; 200 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import fbc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0; // Clock, reset active low
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr; // APB
    logic [7:0] paddr = 8'h00; // APB byte address
    logic [31:0] pwdata = 32'h0, prdata; // APB data
    logic instr_valid = 1'b0, instr_ready; // Instruction handshake
    logic [13:0] instr_code = 14'h0000; // Presented word
    logic [12:0] instr_pc = 13'h0000, pc_target, stack_data, stack_top; // Addresses
    logic [7:0] file_rdata, file_wdata, wdt_value; // Data bytes
    logic [6:0] file_addr; // Write address
    logic file_we, pc_load, stack_push, fetch_flush, wdt_clear, wdt_presc_clear;
    logic timeout_evt = 1'b0, sleep_evt = 1'b0; // Flag events
    logic pre_we = 1'b0; // Preload strobe
    logic [6:0] pre_addr = 7'h00; // Preload address
    logic [7:0] pre_data = 8'h00; // Preload byte
    int error_cnt = 0, n_checks = 0; // Verdict counters
    // Free-running core clock
    always #2.5 clk = ~clk;
    fbc_exec fbc_exec_inst (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .instr_valid, .instr_code, .instr_pc, .file_rdata,
        .instr_ready, .file_we, .file_addr, .file_wdata, .pc_load, .pc_target,
        .stack_push, .stack_data, .fetch_flush, .wdt_clear, .wdt_presc_clear,
        .wdt_value, .timeout_evt, .sleep_evt);
    fbc_core_model fbc_core_model_inst (.clk, .rd_en(instr_valid),
        .rd_addr(instr_code[6:0]), .rd_data(file_rdata), .file_we, .file_addr,
        .file_wdata, .pre_we, .pre_addr, .pre_data, .stack_push, .stack_data,
        .stack_top);
    // Word compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Flag compare
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk1
    // One APB transfer; the request stands until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge so a following setup never reassigns psel at once
        @(posedge clk);
        if (n >= 20) begin
            chk1(1'b0, 1'b1);
        end
    endtask : apb
    // Register write, response must be clean
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
        chk1(err, 1'b0);
    endtask : wr
    // Register read and compare of data and error response
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(rd, exp);
        chk1(err, eerr);
    endtask : rdchk
    // Preload one register file byte in the model
    task automatic pre(input logic [6:0] a, input logic [7:0] d);
        pre_we <= 1'b1;
        pre_addr <= a;
        pre_data <= d;
        @(posedge clk);
        pre_we <= 1'b0;
        @(posedge clk);
    endtask : pre
    // Present a word until taken; returns at the edge that shows its effects
    task automatic issue(input logic [13:0] code, input logic [12:0] pc);
        int n;
        n = 0;
        instr_valid <= 1'b1;
        instr_code <= code;
        instr_pc <= pc;
        do begin
            @(posedge clk);
            n++;
        end while (instr_ready !== 1'b1 && n < 20);
        instr_valid <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            chk1(1'b0, 1'b1);
        end
    endtask : issue
    // Reset values, unmapped access, enable gating
    task automatic t_regs;
        rdchk(FBC_OFS_CTRL, 32'h1, 1'b0);
        rdchk(FBC_OFS_PAGE, 32'h0, 1'b0);
        rdchk(FBC_OFS_ACCUM, 32'h0, 1'b0);
        rdchk(FBC_OFS_STATUS, 32'h6, 1'b0);
        rdchk(8'h10, 32'h0, 1'b1);
        wr(FBC_OFS_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk1(instr_ready, 1'b0);
        wr(FBC_OFS_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        // Word outside the group sets the sticky bit; write one clears it
        issue(14'h0000, 13'h0001);
        rdchk(FBC_OFS_STATUS, 32'he, 1'b0);
        wr(FBC_OFS_STATUS, 32'h8);
        rdchk(FBC_OFS_STATUS, 32'h6, 1'b0);
        $display("test regs done");
    endtask : t_regs
    // AND into accumulator, then into file with zero result
    task automatic t_and;
        wr(FBC_OFS_ACCUM, 32'hf0);
        pre(7'h15, 8'h3c);
        issue({FBC_OP_AND, 1'b0, 7'h15}, 13'h0010);
        chk1(file_we, 1'b0);
        rdchk(FBC_OFS_ACCUM, 32'h30, 1'b0);
        rdchk(FBC_OFS_STATUS, 32'h6, 1'b0);
        pre(7'h16, 8'h0f);
        issue({FBC_OP_AND, 1'b1, 7'h16}, 13'h0011);
        chk1(file_we, 1'b1);
        chk(32'(file_addr), 32'h16);
        chk(32'(file_wdata), 32'h0);
        rdchk(FBC_OFS_ACCUM, 32'h30, 1'b0);
        rdchk(FBC_OFS_STATUS, 32'h7, 1'b0);
        $display("test and done");
    endtask : t_and
    // Every bit position cleared and set; zero flag must survive
    task automatic t_bits;
        for (int b = 0; b < 8; b++) begin
            pre(7'h20, 8'hff);
            issue({FBC_OP_BITOP, FBC_BIT_CLR, 3'(b), 7'h20}, 13'h0020);
            chk1(file_we, 1'b1);
            chk(32'(file_wdata), 32'(8'hff ^ (8'h01 << b)));
            pre(7'h21, 8'h00);
            issue({FBC_OP_BITOP, FBC_BIT_SET, 3'(b), 7'h21}, 13'h0021);
            chk(32'(file_addr), 32'h21);
            chk(32'(file_wdata), 32'(8'h01 << b));
        end
        rdchk(FBC_OFS_STATUS, 32'h7, 1'b0);
        $display("test bits done");
    endtask : t_bits
    // A test word, then a bit set that runs only when no skip is due
    task automatic skip_case(input logic [1:0] kind, input logic [2:0] b,
                             input logic [7:0] fval, input logic skip);
        pre(7'h30, fval);
        pre(7'h31, 8'h00);
        issue({FBC_OP_BITOP, kind, b, 7'h30}, 13'h0030);
        chk1(file_we, 1'b0);
        issue({FBC_OP_BITOP, FBC_BIT_SET, 3'h0, 7'h31}, 13'h0031);
        chk1(file_we, !skip);
    endtask : skip_case
    // Both test kinds, both outcomes, edge bit positions
    task automatic t_skip;
        skip_case(FBC_BIT_TSZ, 3'h7, 8'h7f, 1'b1);
        skip_case(FBC_BIT_TSZ, 3'h7, 8'h80, 1'b0);
        skip_case(FBC_BIT_TSO, 3'h0, 8'h01, 1'b1);
        skip_case(FBC_BIT_TSO, 3'h0, 8'hfe, 1'b0);
        $display("test skip done");
    endtask : t_skip
    // Call with page bits 11, then a call at the top of the space
    task automatic t_call;
        wr(FBC_OFS_PAGE, 32'h1f);
        issue({FBC_OP_CALL, 11'h5a5}, 13'h0abc);
        chk1(stack_push, 1'b1);
        chk(32'(stack_data), 32'h0abd);
        chk1(pc_load, 1'b1);
        chk(32'(pc_target), 32'h1da5);
        chk1(fetch_flush, 1'b1);
        chk1(instr_ready, 1'b0);
        wr(FBC_OFS_PAGE, 32'h08);
        issue({FBC_OP_CALL, 11'h7ff}, 13'h1fff);
        chk(32'(stack_data), 32'h0000);
        chk(32'(pc_target), 32'h0fff);
        @(posedge clk);
        chk(32'(stack_top), 32'h0000);
        rdchk(FBC_OFS_STATUS, 32'h7, 1'b0);
        $display("test call done");
    endtask : t_call
    // Flags dropped by events, restored by the watchdog clear word
    task automatic t_wdt;
        timeout_evt <= 1'b1;
        sleep_evt <= 1'b1;
        @(posedge clk);
        timeout_evt <= 1'b0;
        sleep_evt <= 1'b0;
        @(posedge clk);
        rdchk(FBC_OFS_STATUS, 32'h1, 1'b0);
        issue(FBC_CODE_WDTCLR, 13'h0040);
        chk1(wdt_clear, 1'b1);
        chk1(wdt_presc_clear, 1'b1);
        chk(32'(wdt_value), 32'h0);
        rdchk(FBC_OFS_STATUS, 32'h7, 1'b0);
        $display("test watchdog done");
    endtask : t_wdt
    // File clear from a nonzero flag state, then invert to both destinations
    task automatic t_clr_inv;
        pre(7'h40, 8'hff);
        issue({FBC_OP_AND, 1'b0, 7'h40}, 13'h0050);
        pre(7'h41, 8'h5a);
        issue({FBC_OP_FILE_ZERO_OP, 7'h41}, 13'h0051);
        chk1(file_we, 1'b1);
        chk(32'(file_addr), 32'h41);
        chk(32'(file_wdata), 32'h0);
        rdchk(FBC_OFS_STATUS, 32'h7, 1'b0);
        pre(7'h42, 8'h5a);
        issue({FBC_OP_INV, 1'b0, 7'h42}, 13'h0052);
        chk1(file_we, 1'b0);
        rdchk(FBC_OFS_ACCUM, 32'ha5, 1'b0);
        rdchk(FBC_OFS_STATUS, 32'h6, 1'b0);
        pre(7'h43, 8'hff);
        issue({FBC_OP_INV, 1'b1, 7'h43}, 13'h0053);
        chk(32'(file_wdata), 32'h0);
        rdchk(FBC_OFS_STATUS, 32'h7, 1'b0);
        $display("test clear invert done");
    endtask : t_clr_inv
    // Verdict and end of run
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    // Main sequence: reset for ten cycles, then every scenario
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_regs();
        t_and();
        t_bits();
        t_skip();
        t_call();
        t_wdt();
        t_clr_inv();
        conclude();
    end
    // Watchdog: the scenarios need well under 2000 cycles
    initial begin
        #20000;
        error_cnt++;
        conclude();
    end
endmodule : testbench
`default_nettype wire
